/* core/ras_pkg.sv */
package ras_pkg;
   // stack geometry
   localparam int unsigned DEPTH    = 31;
   localparam int unsigned PC_W     = 21;
   localparam int unsigned PTR_W    = 5;
   // apb register byte offsets
   localparam logic [7:0] OFF_PTR   = 8'h00;
   localparam logic [7:0] OFF_TOPL  = 8'h04;
   localparam logic [7:0] OFF_TOPH  = 8'h08;
   localparam logic [7:0] OFF_TOPU  = 8'h0c;
   localparam logic [7:0] OFF_CFG   = 8'h10;
   // pointer register fields
   localparam int unsigned FULL_BIT = 7;
   localparam int unsigned UNF_BIT  = 6;
   // reset values
   localparam logic [PTR_W-1:0] PTR_RST = 5'h00;
   localparam logic             ORE_RST = 1'b1;
   // pc increment on an overflow push
   localparam logic [PC_W-1:0]  PC_STEP = 21'h000002;
   // vectors
   localparam logic [PC_W-1:0]  VEC_RESET = 21'h000000;
   localparam logic [PC_W-1:0]  VEC_HIGH  = 21'h000008;
   localparam logic [PC_W-1:0]  VEC_LOW   = 21'h000018;

   typedef struct packed {
      logic push;
      logic pop;
      logic [PC_W-1:0] pc;
   } ras_req_s;

   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic            load;
      logic            devReset;
   } ras_rsp_s;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_PUSH = 2'b01,
      OP_POP  = 2'b11
   } ras_op_e;
endpackage

/* core/ras_store.sv */
`timescale 1ns/1ps
module ras_store
   import ras_pkg::*;
#(
   parameter int unsigned N = DEPTH,
   parameter int unsigned W = PC_W
)(
   // clock
   input  wire logic             clock,
   input  wire logic             clockEn,
   // write port
   input  wire logic             we,
   input  wire logic [PTR_W-1:0] wIdx,
   input  wire logic [W-1:0]     wData,
   // read port
   input  wire logic [PTR_W-1:0] rIdx,
   output logic      [W-1:0]     rData
);
   // entries 1..N, index 0 has no storage
   logic [W-1:0] mem_q [1:N];

   always_ff @(posedge clock)
   begin
      if (clockEn && we && wIdx != '0)
      begin
         mem_q[wIdx] <= wData;
      end
   end

   // index zero reads as zero
   always_comb
   begin
      rData = '0;
      if (rIdx != '0)
      begin
         rData = mem_q[rIdx];
      end
   end
endmodule

/* core/ras_apb.sv */
`timescale 1ns/1ps
module ras_apb
   import ras_pkg::*;
(
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   output logic             pready,
   output logic             pslverr,
   // decoded strobes
   output logic             wrPtr,
   output logic             wrTopL,
   output logic             wrTopH,
   output logic             wrTopU,
   output logic             wrCfg,
   output logic             mapped
);
   logic acc;

   always_comb
   begin
      acc     = psel && penable;
      mapped  = paddr == OFF_PTR  || paddr == OFF_TOPL ||
                paddr == OFF_TOPH || paddr == OFF_TOPU ||
                paddr == OFF_CFG;
      pready  = 1'b1;
      pslverr = acc && !mapped;
      wrPtr   = acc && pwrite && paddr == OFF_PTR;
      wrTopL  = acc && pwrite && paddr == OFF_TOPL;
      wrTopH  = acc && pwrite && paddr == OFF_TOPH;
      wrTopU  = acc && pwrite && paddr == OFF_TOPU;
      wrCfg   = acc && pwrite && paddr == OFF_CFG;
   end
endmodule

/* core/return_address_stack.sv */
// Contract
// - 31 entries of 21-bit pc values, 5-bit pointer
// - device reset and overflow reset zero the pointer; zero means empty, no entry
// - call, relative_call and interrupt acknowledge push the pc
// - return, return_with_literal, return_from_interrupt pop to pc
// - pc_upper_latch and pc_high_latch untouched by call and return
// - push increments pointer then writes pc at new pointer
// - pop reads entry at current pointer then decrements
// - top_upper/high/low read and write the entry at the pointer
// - software reads and writes the 5-bit pointer, 0 to 31
// - full flag set after 31 pushes without a pop
// - with overflow reset: 31st push stores pc+2, sets full, resets
// - without: pointer goes to 31, later pushes change nothing
// - pop at zero returns zero, sets underflow, pointer stays zero
// - flags cleared only by software or power-on reset
// - bit7 full, bit6 underflow, bit5 zero, bits4-0 pointer
// - underflow return of zero is not a reset
// - reset vector 0000h, interrupt vectors 0008h and 0018h
// - 21-bit pc spans 2 Mbyte; unimplemented fetches read zero
// - stack storage is apart from program and data memory
// - software push increments pointer and stores current pc
// - software pop discards top by decrementing pointer
`timescale 1ns/1ps
module return_address_stack
   import ras_pkg::*;
(
   // clock and resets
   input  wire logic                clock,
   input  wire logic                reset_n,
   input  wire logic                porReset_n,
   input  wire logic                clockEn,
   // sequencer requests
   input  wire logic                callPush,
   input  wire logic                irqAck,
   input  wire logic                swPush,
   input  wire logic                retPop,
   input  wire logic                swPop,
   input  wire logic [PC_W-1:0]     pcIn,
   // sequencer answers
   output logic      [PC_W-1:0]     pcOut,
   output logic                     pcLoad,
   output logic                     devResetReq,
   // vectors and fetch guard
   output logic      [PC_W-1:0]     vecReset,
   output logic      [PC_W-1:0]     vecHigh,
   output logic      [PC_W-1:0]     vecLow,
   input  wire logic [PC_W-1:0]     fetchAddr,
   input  wire logic [PC_W-1:0]     memTop,
   input  wire logic [15:0]         memData,
   output logic      [15:0]         fetchData,
   // apb
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr
);
   logic [PTR_W-1:0] ptr_q;
   logic             full_q;
   logic             unf_q;
   logic             ore_q;
   logic [PC_W-1:0]  pcOut_q;
   logic             pcLoad_q;
   logic             devRst_q;
   logic [PC_W-1:0]  top;
   logic             wrPtr, wrTopL, wrTopH, wrTopU, wrCfg, mapped;
   logic             doPush, doPop, atTop, memWe;
   logic [PC_W-1:0]  memWData;
   logic [PTR_W-1:0] memIdx;
   ras_req_s         req;
   ras_op_e          op;

   // pc value with one byte lane replaced
   function automatic logic [PC_W-1:0] put_lane(
      input logic [PC_W-1:0] v, input logic [7:0] b, input int unsigned s);
      logic [PC_W-1:0] m;
      m = PC_W'(8'hff) << s;
      put_lane = (v & ~m) | ((PC_W'(b) << s) & m);
   endfunction

   assign req.push = callPush || irqAck || swPush;
   assign req.pop  = retPop || swPop;
   assign req.pc   = pcIn;
   assign op       = req.push ? OP_PUSH : (req.pop ? OP_POP : OP_NONE);
   assign doPush   = op == OP_PUSH;
   assign doPop    = op == OP_POP;
   assign atTop    = ptr_q == PTR_W'(DEPTH);
   ras_apb u_apb (
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pready  (pready),
      .pslverr (pslverr),
      .wrPtr   (wrPtr),
      .wrTopL  (wrTopL),
      .wrTopH  (wrTopH),
      .wrTopU  (wrTopU),
      .wrCfg   (wrCfg),
      .mapped  (mapped)
   );

   // write port: push writes at pointer+1, software at pointer
   always_comb
   begin
      memWe    = 1'b0;
      memIdx   = ptr_q;
      memWData = top;
      if (doPush && !atTop)
      begin
         memWe  = 1'b1;
         memIdx = ptr_q + 5'h01;
         memWData = (memIdx == PTR_W'(DEPTH) && ore_q) ?
                    req.pc + PC_STEP : req.pc;
      end
      else if (wrTopL || wrTopH || wrTopU)
      begin
         memWe = 1'b1;
         if (wrTopL)
            memWData = put_lane(top, pwdata[7:0], 0);
         else if (wrTopH)
            memWData = put_lane(top, pwdata[7:0], 8);
         else
            memWData = put_lane(top, pwdata[7:0], 16);
      end
   end

   ras_store #(.N(DEPTH), .W(PC_W)) u_store (
      .clock   (clock),
      .clockEn (clockEn),
      .we      (memWe),
      .wIdx    (memIdx),
      .wData   (memWData),
      .rIdx    (ptr_q),
      .rData   (top)
   );

   // pointer: device reset and overflow reset clear it, power-on reset alone does not
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         ptr_q <= PTR_RST;
      else if (clockEn)
      begin
         if (devRst_q)
            ptr_q <= PTR_RST;
         else if (doPush)
         begin
            if (!atTop)
               ptr_q <= (ptr_q == PTR_W'(DEPTH-1) && ore_q) ?
                        PTR_RST : ptr_q + 5'h01;
         end
         else if (doPop)
         begin
            if (ptr_q != '0)
               ptr_q <= ptr_q - 5'h01;
         end
         else if (wrPtr)
            ptr_q <= pwdata[PTR_W-1:0];
      end
   end

   // flags: only software or power-on reset clears them, set wins over clear
   always_ff @(posedge clock or negedge porReset_n)
   begin
      if (!porReset_n)
      begin
         full_q <= 1'b0;
         unf_q  <= 1'b0;
      end
      else if (clockEn)
      begin
         if (doPush && ptr_q >= PTR_W'(DEPTH-1))
            full_q <= 1'b1;
         else if (wrPtr && !pwdata[FULL_BIT])
            full_q <= 1'b0;
         if (doPop && ptr_q == '0)
            unf_q <= 1'b1;
         else if (wrPtr && !pwdata[UNF_BIT])
            unf_q <= 1'b0;
      end
   end

   // overflow reset enable, kept across device resets
   always_ff @(posedge clock or negedge porReset_n)
   begin
      if (!porReset_n)
         ore_q <= ORE_RST;
      else if (clockEn && wrCfg)
         ore_q <= pwdata[0];
   end

   // pc answer; underflow loads zero without any reset
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pcOut_q  <= '0;
         pcLoad_q <= 1'b0;
         devRst_q <= 1'b0;
      end
      else if (clockEn)
      begin
         pcLoad_q <= doPop && retPop;
         if (doPop)
            pcOut_q <= top;
         devRst_q <= doPush && ore_q &&
                     ptr_q == PTR_W'(DEPTH-1);
      end
   end

   assign pcOut       = pcOut_q;
   assign pcLoad      = pcLoad_q;
   assign devResetReq = devRst_q;
   assign vecReset    = VEC_RESET;
   assign vecHigh     = VEC_HIGH;
   assign vecLow      = VEC_LOW;
   assign fetchData   = (fetchAddr > memTop) ? 16'h0000 : memData;

   // register read-back
   always_comb
   begin
      prdata = '0;
      if (mapped)
      begin
         unique case (paddr)
            OFF_PTR:  prdata = {24'h0, full_q, unf_q, 1'b0, ptr_q};
            OFF_TOPL: prdata = {24'h000000, top[7:0]};
            OFF_TOPH: prdata = {24'h000000, top[15:8]};
            OFF_TOPU: prdata = {27'h0000000, top[20:16]};
            OFF_CFG:  prdata = {31'h00000000, ore_q};
            default:  prdata = '0;
         endcase
      end
   end

   // assertions
   property p_push_inc;
      @(posedge clock) disable iff (!reset_n)
      clockEn && doPush && ptr_q < 5'd30 && !devRst_q
      |=> ptr_q == $past(ptr_q) + 5'h01;
   endproperty
   a_push_inc: assert property (p_push_inc) else $error("push inc");

   property p_pop_dec;
      @(posedge clock) disable iff (!reset_n)
      clockEn && doPop && ptr_q != '0 && !devRst_q
      |=> ptr_q == $past(ptr_q) - 5'h01 && pcOut == $past(top);
   endproperty
   a_pop_dec: assert property (p_pop_dec) else $error("pop dec");

   property p_unf;
      @(posedge clock) disable iff (!reset_n || !porReset_n)
      clockEn && doPop && ptr_q == '0 && !devRst_q
      |=> unf_q && ptr_q == '0 && pcOut == '0;
   endproperty
   a_unf: assert property (p_unf) else $error("underflow");

   property p_full;
      @(posedge clock) disable iff (!reset_n || !porReset_n)
      clockEn && doPush && ptr_q == 5'd30 |=> full_q;
   endproperty
   a_full: assert property (p_full) else $error("full");

   sequence s_ovr_push;
      clockEn && doPush && ore_q && ptr_q == 5'h1e;
   endsequence

   sequence s_ovr_done;
      devResetReq && full_q && ptr_q == '0;
   endsequence

   property p_ovr_rst;
      @(posedge clock) disable iff (!reset_n || !porReset_n)
      s_ovr_push |=> s_ovr_done;
   endproperty
   a_ovr_rst: assert property (p_ovr_rst) else $error("ovr rst");

   property p_sat;
      @(posedge clock) disable iff (!reset_n)
      clockEn && doPush && ptr_q == 5'd31 |=> ptr_q == 5'd31;
   endproperty
   a_sat: assert property (p_sat) else $error("saturate");

   property p_sticky;
      @(posedge clock) disable iff (!porReset_n)
      full_q && !(clockEn && wrPtr && !pwdata[FULL_BIT]) |=> full_q;
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky");

   property p_fmt;
      @(posedge clock) disable iff (!reset_n)
      paddr == OFF_PTR |-> prdata[5] == 1'b0 && prdata[4:0] == ptr_q;
   endproperty
   a_fmt: assert property (p_fmt) else $error("format");

   // a low enable holds the pointer, both flags, pcLoad_q and the top entry
   property p_freeze;
      @(posedge clock) disable iff (!reset_n || !porReset_n)
      !clockEn |=> $stable(ptr_q) && $stable(full_q) && $stable(unf_q)
                   && $stable(pcLoad_q) && $stable(top);
   endproperty
   a_freeze: assert property (p_freeze) else $error("freeze");

   property p_ret_load;
      @(posedge clock) disable iff (!reset_n)
      clockEn && doPop && retPop |=> pcLoad;
   endproperty
   a_ret_load: assert property (p_ret_load) else $error("ret load");

   property p_swpop;
      @(posedge clock) disable iff (!reset_n)
      clockEn && doPop && !retPop |=> !pcLoad;
   endproperty
   a_swpop: assert property (p_swpop) else $error("sw pop load");

   property p_no_unf_rst;
      @(posedge clock) disable iff (!reset_n)
      clockEn && doPop |=> !devResetReq;
   endproperty
   a_no_unf_rst: assert property (p_no_unf_rst) else $error("pop rst");

   property p_ptr_wr;
      @(posedge clock) disable iff (!reset_n)
      clockEn && wrPtr && !doPush && !doPop && !devRst_q
      |=> ptr_q == $past(pwdata[PTR_W-1:0]);
   endproperty
   a_ptr_wr: assert property (p_ptr_wr) else $error("ptr write");

   property p_unf_sticky;
      @(posedge clock) disable iff (!porReset_n)
      unf_q && !(clockEn && wrPtr && !pwdata[UNF_BIT]) |=> unf_q;
   endproperty
   a_unf_sticky: assert property (p_unf_sticky) else $error("unf sticky");

   property p_sat_top;
      @(posedge clock) disable iff (!reset_n)
      clockEn && doPush && ptr_q == 5'h1f |=> top == $past(top);
   endproperty
   a_sat_top: assert property (p_sat_top) else $error("top kept");
endmodule

/* verification/ras_seq_model.sv */
`timescale 1ns/1ps
module ras_seq_model
   import ras_pkg::*;
(
   // clock
   input  wire logic            clock,
   // requests
   output logic                 callPush,
   output logic                 irqAck,
   output logic                 swPush,
   output logic                 retPop,
   output logic                 swPop,
   output logic      [PC_W-1:0] pcIn
);
   initial
   begin
      {callPush, irqAck, swPush, retPop, swPop} = 5'h00;
      pcIn = '0;
   end
   // one-cycle request; m = call, irq, swpush, ret, swpop
   task automatic req(input logic [4:0] m, input logic [PC_W-1:0] pc);
      @(posedge clock);
      {callPush, irqAck, swPush, retPop, swPop} <= m;
      pcIn <= pc;
      @(posedge clock);
      {callPush, irqAck, swPush, retPop, swPop} <= 5'h00;
      pcIn <= ~pc;
   endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
   import ras_pkg::*;
   logic            clock, reset_n, porReset_n, clockEn, pcLoad;
   logic            callPush, irqAck, swPush, retPop, swPop;
   logic [PC_W-1:0] pcIn, pcOut, vecReset, vecHigh, vecLow;
   logic [PC_W-1:0] fetchAddr, memTop;
   logic [15:0]     memData, fetchData;
   logic            devResetReq, psel, penable, pwrite, pready;
   logic            pslverr, err, sawRst;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rd;
   int              errors, compares;

   ras_seq_model u_seq (.clock, .callPush, .irqAck, .swPush, .retPop,
      .swPop, .pcIn);
   return_address_stack u_return_address_stack (.clock, .reset_n,
      .porReset_n, .clockEn, .callPush, .irqAck, .swPush, .retPop, .swPop,
      .pcIn, .pcOut, .pcLoad, .devResetReq, .vecReset, .vecHigh, .vecLow,
      .fetchAddr, .memTop, .memData, .fetchData, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr);

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock)
      if (devResetReq === 1'b1)
         sawRst <= 1'b1;

   task automatic tally_and_finish;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string m);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %0t %s %h/%h", $time, m, got, exp);
      end
   endtask
   // apb transfer; the sequencer stays idle meanwhile
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, e}, "read");
   endtask
   task automatic top(input logic [PC_W-1:0] pc);
      rdchk(OFF_TOPL, pc[7:0]);
      rdchk(OFF_TOPH, pc[15:8]);
      rdchk(OFF_TOPU, {3'h0, pc[20:16]});
   endtask
   task automatic popchk(input logic [4:0] m, input logic [PC_W-1:0] e);
      u_seq.req(m, 21'h0);
      #1;
      chk({31'h0, pcLoad}, 32'h1, "load");
      chk(32'(pcOut), 32'(e), "pop");
   endtask

   task automatic t_static;
      rdchk(OFF_PTR, 8'h00);
      chk(32'(vecReset), 32'h0, "vec");
      chk(32'(vecHigh), 32'h8, "vec");
      chk(32'(vecLow), 32'h18, "vec");
      @(posedge clock);
      fetchAddr <= 21'h001000;
      @(posedge clock);
      chk(32'(fetchData), 32'h0, "fetch");
      fetchAddr <= 21'h000ffe;
      @(posedge clock);
      chk(32'(fetchData), 32'ha5c3, "fetch");
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped");
      chk(rd, 32'h0, "unmapped data");
   endtask
   task automatic t_calls;
      u_seq.req(5'h10, 21'h012346);
      u_seq.req(5'h08, 21'h000124);
      u_seq.req(5'h04, 21'h1abcde);
      rdchk(OFF_PTR, 8'h03);
      top(21'h1abcde);
      popchk(5'h02, 21'h1abcde);
      u_seq.req(5'h01, 21'h0);
      #1;
      chk({31'h0, pcLoad}, 32'h0, "discard");
      rdchk(OFF_PTR, 8'h01);
      top(21'h012346);
      popchk(5'h02, 21'h012346);
      popchk(5'h02, 21'h0);
      rdchk(OFF_PTR, 8'h40);
      apb(1'b1, OFF_PTR, 32'hc0);
      rdchk(OFF_PTR, 8'h40);
      apb(1'b1, OFF_PTR, 32'h05);
      rdchk(OFF_PTR, 8'h05);
      apb(1'b1, OFF_TOPL, 32'h77);
      apb(1'b1, OFF_TOPH, 32'h66);
      apb(1'b1, OFF_TOPU, 32'h15);
      popchk(5'h02, 21'h156677);
      rdchk(OFF_PTR, 8'h04);
      clockEn <= 1'b0;
      u_seq.req(5'h10, 21'h000abc);
      rdchk(OFF_PTR, 8'h04);
      clockEn <= 1'b1;
   endtask
   task automatic t_full(input logic ore, input logic [7:0] e);
      apb(1'b1, OFF_CFG, {31'h0, ore});
      apb(1'b1, OFF_PTR, 32'h0);
      sawRst = 1'b0;
      for (int i = 1; i <= 31; i++)
         u_seq.req(5'h10, 21'h010000 + 21'(2 * i));
      @(posedge clock);
      #1;
      chk({31'h0, sawRst}, {31'h0, ore}, "ovf reset");
      rdchk(OFF_PTR, e);
   endtask

   initial
   begin
      {reset_n, porReset_n, clockEn} = 3'b001;
      {psel, penable, pwrite, sawRst} = 4'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      fetchAddr = 21'h0;
      memTop = 21'h000fff;
      memData = 16'ha5c3;
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      porReset_n <= 1'b1;
      t_static();
      t_calls();
      t_full(1'b1, 8'h80);
      apb(1'b1, OFF_PTR, 32'h9f);
      top(21'h010040);
      @(posedge clock);
      reset_n <= 1'b0;
      @(posedge clock);
      reset_n <= 1'b1;
      rdchk(OFF_PTR, 8'h80);
      t_full(1'b0, 8'h9f);
      u_seq.req(5'h10, 21'h1ffffe);
      rdchk(OFF_PTR, 8'h9f);
      top(21'h01003e);
      tally_and_finish();
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      errors++;
      tally_and_finish();
   end
endmodule
